// ==== verilog/motor_supervisor_pkg.sv ====
// Purpose: Shared constants and types for the motor controller supervisor.
// Assumes: Core clock of 200 MHz.
// Notes:   Times are in milliseconds; cycle counts derive from them.
package motor_supervisor_pkg;
	localparam int CLK_MHZ        = 200;
	localparam int BLINK_MS       = 100;
	localparam int PAUSE_MS       = 1000;
	localparam int FLICKER_MS     = 25;
	localparam int BLINK_CYC      = BLINK_MS * CLK_MHZ * 1000;
	localparam int PAUSE_CYC      = PAUSE_MS * CLK_MHZ * 1000;
	localparam int FLICKER_CYC    = FLICKER_MS * CLK_MHZ * 1000;
	localparam int TEST_FLASHES   = 3;
	localparam int NUM_SW         = 10;
	localparam int SW_MODE1       = 0;
	localparam int SW_MODE2       = 1;
	localparam int SW_MODE3       = 2;
	localparam int SW_FLIP_TYPE   = 6;
	localparam int SW_CUT0        = 7;
	localparam int ENC_W          = 32;
	localparam logic [2:0] CUT_NONE  = 3'h0;
	localparam logic [2:0] CUT_LEAD  = 3'h1;
	localparam logic [2:0] CUT_FIRST = 3'h2;
	localparam logic [15:0] CUT_BASE_MV  = 16'h1770;
	localparam logic [15:0] CUT_STEP_MV  = 16'h0BB8;
	localparam logic [15:0] LEAD_AUTO_MV = 16'h2904;
	localparam logic [11:0] REG_STATUS = 12'h000;
	localparam logic [11:0] REG_ENC1   = 12'h004;
	localparam logic [11:0] REG_ENC2   = 12'h008;
	localparam logic [11:0] REG_CTRL   = 12'h00C;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		MODE_SERVO, MODE_ANALOG, MODE_SIMPLE_SERIAL, MODE_PACKET_SERIAL
	} mode_t;
	typedef enum logic [2:0] {
		ERR_NONE, ERR_OVERCUR, ERR_OVERTEMP, ERR_MAIN_HIGH,
		ERR_MAIN_LOW, ERR_LOGIC_LOW, ERR_LOGIC_HIGH
	} err_t;
	typedef enum logic {LED_TEST, LED_RUN} led_state_t;
endpackage

// ==== verilog/enc_if.sv ====
// Purpose: Carries one encoder counter and its clear between modules.
// Assumes: Single core clock domain.
// Notes:   The decoder drives the count, the owner drives the clear.
`timescale 1ns/1ps
interface enc_if;
	import motor_supervisor_pkg::*;
	logic [ENC_W-1:0] count;
	logic             clear;
	modport decoder (input clear, output count);
	modport owner (output clear, input count);
endinterface

// ==== verilog/quad_decoder.sv ====
// Purpose: One quadrature encoder channel decoded into a position counter.
// Assumes: Phase pins are asynchronous and pass two flip-flops first.
// Notes:   Illegal double steps are ignored.
`timescale 1ns/1ps
module quad_decoder (
	input  wire logic core_clk_in,  // Core clock.
	input  wire logic rst_in,       // Asynchronous reset, active high.
	input  wire logic phase_a_in,   // Encoder phase A pin.
	input  wire logic phase_b_in,   // Encoder phase B pin.
	enc_if.decoder    enc           // Counter and clear.
);
	import motor_supervisor_pkg::*;
	logic [1:0] meta;
	logic [1:0] sync;
	logic [1:0] prev;
	wire  [3:0] step = {prev, sync};
	wire        step_up = (step == 4'h2) || (step == 4'hB) ||
	                      (step == 4'hD) || (step == 4'h4);
	wire        step_dn = (step == 4'h1) || (step == 4'h7) ||
	                      (step == 4'hE) || (step == 4'h8);

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			meta <= 2'h0;
			sync <= 2'h0;
			prev <= 2'h0;
		end else begin
			meta <= {phase_a_in, phase_b_in};
			sync <= meta;
			prev <= sync;
		end
	end

	// A leading B counts up, the reverse counts down.
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			enc.count <= '0;
		end else if (enc.clear) begin
			enc.count <= '0;
		end else if (step_up) begin
			enc.count <= enc.count + 1'b1;
		end else if (step_dn) begin
			enc.count <= enc.count - 1'b1;
		end
	end
endmodule

// ==== verilog/motor_supervisor.sv ====
// Purpose: Supervisor of a dual brushed-motor controller: modes, cutoff,
//          stop and flip inputs, encoders and the three indicators.
// Assumes: Fault and activity inputs come from core-clock logic.
// Notes:   Registers are reached over AXI4-Lite.
//
// Implementation choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
// Overview of operation
// - At power-up flash all three indicators together three short times.
// - Analog mode: first status lit steadily, second lit while a motor runs.
// - Servo mode: first status lit, blinks per received pulse; second shows activity.
// - Serial modes: first status lit, blinks per received byte; second shows activity.
// - Over-current: error lit solid, status indicators show which channel tripped.
// - Over-temperature: error repeats one blink then a long pause.
// - Main supply low: error repeats two blinks then a long pause.
// - Main supply high: error flickers fast until the condition clears.
// - Logic supply low: error repeats three blinks then a long pause.
// - Logic supply high: error repeats four blinks then a long pause.
// - Serial modes: third control input is an active-low emergency stop.
// - Servo mode with switch seven off and analog mode with switch seven on: third control input is the flip input.
// - Ten switches are read; a switch toward its mark reads on.
// - Switches eight to ten select no monitoring, lead-acid or 6V to 21V cutoff.
// - Main supply below the selected cutoff stops the motors.
// - Servo mode takes commands from pulses and ignores encoder feedback.
// - Analog mode ignores encoder feedback.
// - Two encoder counters count up when A leads B, down when B leads.
// - Switch one on selects servo mode; switches one to three off select analog.
// - Logic-level flip input low means flipped and reverses control.
module motor_supervisor #(
	parameter int BLINK_CYCLES   = motor_supervisor_pkg::BLINK_CYC,
	parameter int PAUSE_CYCLES   = motor_supervisor_pkg::PAUSE_CYC,
	parameter int FLICKER_CYCLES = motor_supervisor_pkg::FLICKER_CYC
) (
	input  wire logic                                   core_clk_in,            // Core clock.
	input  wire logic                                   rst_in,                 // Async reset.
	input  wire logic [motor_supervisor_pkg::NUM_SW-1:0] switches_in,           // Switch pins.
	input  wire logic                                   flip_or_estop_input_in, // Third input.
	input  wire logic                                   enc1_a_in,              // Enc 1 A.
	input  wire logic                                   enc1_b_in,              // Enc 1 B.
	input  wire logic                                   enc2_a_in,              // Enc 2 A.
	input  wire logic                                   enc2_b_in,              // Enc 2 B.
	input  wire logic                                   cmd_pulse_seen_in,      // Pulse event.
	input  wire logic                                   serial_byte_seen_in,    // Byte event.
	input  wire logic                                   motor1_active_in,       // M1 driven.
	input  wire logic                                   motor2_active_in,       // M2 driven.
	input  wire logic                                   overcurrent1_in,        // M1 trip.
	input  wire logic                                   overcurrent2_in,        // M2 trip.
	input  wire logic                                   overtemp_in,            // Too hot.
	input  wire logic                                   main_high_in,           // Main high.
	input  wire logic                                   logic_low_in,           // Logic low.
	input  wire logic                                   logic_high_in,          // Logic high.
	input  wire logic [15:0]                            main_supply_mv_in,      // Main mV.
	input  wire logic [11:0]                            s_axi_awaddr,           // AW addr.
	input  wire logic                                   s_axi_awvalid,          // AW valid.
	output logic                                        s_axi_awready,          // AW ready.
	input  wire logic [31:0]                            s_axi_wdata,            // W data.
	input  wire logic [3:0]                             s_axi_wstrb,            // W strobes.
	input  wire logic                                   s_axi_wvalid,           // W valid.
	output logic                                        s_axi_wready,           // W ready.
	output logic [1:0]                                  s_axi_bresp,            // B resp.
	output logic                                        s_axi_bvalid,           // B valid.
	input  wire logic                                   s_axi_bready,           // B ready.
	input  wire logic [11:0]                            s_axi_araddr,           // AR addr.
	input  wire logic                                   s_axi_arvalid,          // AR valid.
	output logic                                        s_axi_arready,          // AR ready.
	output logic [31:0]                                 s_axi_rdata,            // R data.
	output logic [1:0]                                  s_axi_rresp,            // R resp.
	output logic                                        s_axi_rvalid,           // R valid.
	input  wire logic                                   s_axi_rready,           // R ready.
	output logic                                        status_led1_out,        // Status 1.
	output logic                                        status_led2_out,        // Status 2.
	output logic                                        error_led_out,          // Error.
	output motor_supervisor_pkg::mode_t                 mode_out,               // Mode.
	output logic                                        estop_out,              // Stop.
	output logic                                        flip_out,               // Flipped.
	output logic                                        motor_enable_out,       // Run ok.
	output logic                                        feedback_enable_out     // Enc use.
);
	import motor_supervisor_pkg::*;

	logic [NUM_SW-1:0] sw_meta;
	logic [NUM_SW-1:0] sw_sync;
	logic [1:0]        s3_meta;
	logic              s3_sync;
	logic [1:0]        ctrl;
	led_state_t        led_state;
	err_t              shown_err;
	logic [3:0]        slot;
	logic [31:0]       tmr;
	logic [31:0]       flick_tmr;
	logic              flicker;
	logic [31:0]       dark_tmr;
	enc_if             enc1 ();
	enc_if             enc2 ();

	// Switch and third-input pins are resynchronised; on reads as one.
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			sw_meta <= '0;
			sw_sync <= '0;
			s3_meta <= 2'h3;
		end else begin
			sw_meta <= switches_in;
			sw_sync <= sw_meta;
			s3_meta <= {s3_meta[0], flip_or_estop_input_in};
		end
	end
	assign s3_sync = s3_meta[1];

	wire       sw1       = sw_sync[SW_MODE1];
	wire       sw2       = sw_sync[SW_MODE2];
	wire       sw3       = sw_sync[SW_MODE3];
	wire [2:0] cut_code  = sw_sync[SW_CUT0 +: 3];
	wire       is_servo  = sw1;
	wire       is_analog = !sw1 && !sw2 && !sw3;
	wire       is_serial = !is_servo && !is_analog;
	assign mode_out = is_servo ? MODE_SERVO : is_analog ? MODE_ANALOG :
	                  sw2 ? MODE_SIMPLE_SERIAL : MODE_PACKET_SERIAL;

	// Stop input is pulled up off chip, so only a real low trips it.
	assign estop_out = is_serial && !s3_sync;
	wire flip_ttl = (is_servo && !sw_sync[SW_FLIP_TYPE]) ||
	                (is_analog && sw_sync[SW_FLIP_TYPE]);
	assign flip_out = flip_ttl && !s3_sync;
	assign feedback_enable_out = is_serial;

	wire [15:0] cut_steps = {13'h0000, cut_code - CUT_FIRST};
	wire [15:0] cut_mv    = (cut_code == CUT_LEAD) ? LEAD_AUTO_MV :
	                        16'(CUT_BASE_MV + cut_steps * CUT_STEP_MV);
	wire        undervolt = (cut_code != CUT_NONE) &&
	                        (main_supply_mv_in < cut_mv);
	assign motor_enable_out = !estop_out && !undervolt;

	wire   oc = overcurrent1_in || overcurrent2_in;
	err_t  act_err;
	assign act_err = oc ? ERR_OVERCUR : overtemp_in ? ERR_OVERTEMP :
	                 main_high_in ? ERR_MAIN_HIGH : undervolt ? ERR_MAIN_LOW :
	                 logic_low_in ? ERR_LOGIC_LOW :
	                 logic_high_in ? ERR_LOGIC_HIGH : ERR_NONE;

	logic [3:0] blinks;
	always_comb begin
		blinks = 4'h0;
		if (led_state == LED_TEST) begin
			blinks = 4'(TEST_FLASHES);
		end else begin
			case (shown_err)
				ERR_OVERTEMP:   blinks = 4'h1;
				ERR_MAIN_LOW:   blinks = 4'h2;
				ERR_LOGIC_LOW:  blinks = 4'h3;
				ERR_LOGIC_HIGH: blinks = 4'h4;
				default:        blinks = 4'h0;
			endcase
		end
	end

	wire [3:0] last_blink = 4'({blinks, 1'b0} - 5'h01);
	wire       pulse_on   = !slot[0] && (slot < {blinks[2:0], 1'b0});
	wire       tmr_done   = (tmr == 32'h0000_0000);
	wire       err_change = (led_state == LED_RUN) && (act_err != shown_err);

	// Slot engine: even slots lit, odd slots dark, then one long pause slot, except in the self-test.
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			// The first self-test flash lasts a full blink from release.
			led_state <= LED_TEST;
			shown_err <= ERR_NONE;
			slot      <= 4'h0;
			tmr       <= 32'(BLINK_CYCLES - 1);
		end else if (err_change) begin
			shown_err <= act_err;
			slot      <= 4'h0;
			tmr       <= 32'(BLINK_CYCLES - 1);
		end else if (!tmr_done) begin
			tmr <= tmr - 32'h0000_0001;
		end else if (slot < last_blink) begin
			slot <= slot + 4'h1;
			tmr  <= 32'(BLINK_CYCLES - 1);
		end else if (led_state == LED_TEST) begin
			led_state <= LED_RUN;
			slot      <= 4'h0;
		end else if (slot == last_blink) begin
			slot <= slot + 4'h1;
			tmr  <= 32'(PAUSE_CYCLES - 1);
		end else begin
			slot <= 4'h0;
			tmr  <= 32'(BLINK_CYCLES - 1);
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			flick_tmr <= 32'h0000_0000;
			flicker   <= 1'b0;
		end else if (flick_tmr == 32'h0000_0000) begin
			flick_tmr <= 32'(FLICKER_CYCLES - 1);
			flicker   <= !flicker;
		end else begin
			flick_tmr <= flick_tmr - 32'h0000_0001;
		end
	end

	wire act_event = (is_servo && cmd_pulse_seen_in) ||
	                 (is_serial && serial_byte_seen_in);
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			dark_tmr <= 32'h0000_0000;
		end else if (act_event) begin
			dark_tmr <= 32'(BLINK_CYCLES - 1);
		end else if (dark_tmr != 32'h0000_0000) begin
			dark_tmr <= dark_tmr - 32'h0000_0001;
		end
	end

	wire testing    = (led_state == LED_TEST);
	wire show_oc    = !testing && (shown_err == ERR_OVERCUR);
	wire led1_base  = is_analog || (dark_tmr == 32'h0000_0000);
	wire motor_any  = motor1_active_in || motor2_active_in;
	wire err_normal = (shown_err == ERR_OVERCUR) ? 1'b1 :
	                  (shown_err == ERR_MAIN_HIGH) ? flicker :
	                  (shown_err == ERR_NONE) ? 1'b0 : pulse_on;

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			status_led1_out <= 1'b0;
			status_led2_out <= 1'b0;
			error_led_out   <= 1'b0;
		end else if (testing) begin
			status_led1_out <= pulse_on;
			status_led2_out <= pulse_on;
			error_led_out   <= pulse_on;
		end else if (show_oc) begin
			status_led1_out <= overcurrent1_in;
			status_led2_out <= overcurrent2_in;
			error_led_out   <= 1'b1;
		end else begin
			status_led1_out <= led1_base;
			status_led2_out <= motor_any;
			error_led_out   <= err_normal;
		end
	end

	assign enc1.clear = ctrl[0];
	assign enc2.clear = ctrl[1];
	quad_decoder u_enc1 (
		.core_clk_in (core_clk_in),
		.rst_in      (rst_in),
		.phase_a_in  (enc1_a_in),
		.phase_b_in  (enc1_b_in),
		.enc         (enc1.decoder)
	);
	quad_decoder u_enc2 (
		.core_clk_in (core_clk_in),
		.rst_in      (rst_in),
		.phase_a_in  (enc2_a_in),
		.phase_b_in  (enc2_b_in),
		.enc         (enc2.decoder)
	);

	// Write takes address and data together; read answers one cycle later.
	wire wr_take = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	wire wr_ctrl = (s_axi_awaddr == REG_CTRL);
	wire wr_ok   = wr_ctrl || (s_axi_awaddr == REG_STATUS) ||
	               (s_axi_awaddr == REG_ENC1) || (s_axi_awaddr == REG_ENC2);
	wire rd_take = s_axi_arvalid && !s_axi_rvalid;
	assign s_axi_awready = wr_take;
	assign s_axi_wready  = wr_take;
	assign s_axi_arready = !s_axi_rvalid;

	wire [31:0] status_word = {20'h0_0000, testing, shown_err, undervolt,
	                           flip_out, estop_out, cut_code, mode_out};
	logic [31:0] rd_word;
	logic        rd_hit;
	always_comb begin
		rd_word = 32'h0000_0000;
		rd_hit  = 1'b1;
		if (s_axi_araddr == REG_STATUS) begin
			rd_word = status_word;
		end else if (s_axi_araddr == REG_ENC1) begin
			rd_word = enc1.count;
		end else if (s_axi_araddr == REG_ENC2) begin
			rd_word = enc2.count;
		end else if (s_axi_araddr == REG_CTRL) begin
			rd_word = {30'h0000_0000, ctrl};
		end else begin
			rd_hit = 1'b0;
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ctrl         <= 2'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (wr_take) begin
			if (wr_ctrl && s_axi_wstrb[0]) begin
				ctrl <= s_axi_wdata[1:0];
			end
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= RESP_OKAY;
		end else if (rd_take) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
			s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (rst_in);

	test_flash_a: assert property (
		testing |=> (status_led1_out == error_led_out) &&
		            (status_led2_out == error_led_out))
		else $error("Self-test indicators not flashing together.");
	analog_led1_a: assert property (
		!testing && is_analog && !show_oc |=> status_led1_out)
		else $error("Analog mode first indicator not lit.");
	active_led2_a: assert property (
		!testing && !show_oc && motor_any |=> status_led2_out)
		else $error("Second indicator not showing motor activity.");
	pulse_blink_a: assert property (
		is_servo && cmd_pulse_seen_in && !testing && !show_oc
		|=> ##1 !status_led1_out)
		else $error("First indicator did not blink on pulse.");
	byte_blink_a: assert property (
		is_serial && serial_byte_seen_in && !testing && !show_oc
		|=> ##1 !status_led1_out)
		else $error("First indicator did not blink on byte.");
	oc_solid_a: assert property (
		show_oc |=> error_led_out && (status_led1_out == $past(overcurrent1_in)))
		else $error("Over-current indication wrong.");
	oc_first_a: assert property (
		oc && !testing |=> shown_err == ERR_OVERCUR)
		else $error("Over-current not given priority.");
	estop_stop_a: assert property (
		is_serial && !$past(rst_in) && !$past(rst_in, 2) &&
		$past(!flip_or_estop_input_in, 2)
		|-> estop_out && !motor_enable_out)
		else $error("Emergency stop did not stop motors.");
	cutoff_stop_a: assert property (
		(cut_code >= CUT_FIRST) && (main_supply_mv_in < CUT_BASE_MV)
		|-> !motor_enable_out)
		else $error("Supply below cutoff did not stop motors.");
	servo_mode_a: assert property (
		sw1 |-> (mode_out == MODE_SERVO) && !feedback_enable_out)
		else $error("Switch one did not select servo mode.");

	test_done_c:  cover property (testing ##1 !testing);
	temp_show_c:  cover property (shown_err == ERR_OVERTEMP && error_led_out);
	estop_seen_c: cover property ($rose(estop_out));
	enc_move_c:   cover property (enc1.count != $past(enc1.count));
endmodule

// ==== verification/field_model.sv ====
// Purpose: Far-side model of the two quadrature encoders and the third control line.
// Assumes: The bench spaces step requests several cycles apart.
// Notes:   Undriven, the third line sits high through its pull-up.
`timescale 1ns/1ps
module field_model (
	input  wire logic core_clk_in, // Core clock.
	input  wire logic step_in,     // Step request.
	input  wire logic chan_in,     // Encoder select.
	input  wire logic up_in,       // Step with A leading.
	input  wire logic low_in,      // Pull the third line low.
	output logic      a1_out,      // Encoder one A.
	output logic      b1_out,      // Encoder one B.
	output logic      a2_out,      // Encoder two A.
	output logic      b2_out,      // Encoder two B.
	output logic      third_out    // Third control line.
);
	logic [1:0] q1 = 2'h0;
	logic [1:0] q2 = 2'h0;
	// Phase index 0 to 3 maps to AB 00, 10, 11, 01.
	assign a1_out = q1[0] ^ q1[1];
	assign b1_out = q1[1];
	assign a2_out = q2[0] ^ q2[1];
	assign b2_out = q2[1];
	assign third_out = !low_in;
	always @(posedge core_clk_in) begin
		if (step_in && !chan_in)
			q1 <= up_in ? q1 + 2'h1 : q1 - 2'h1;
		if (step_in && chan_in)
			q2 <= up_in ? q2 + 2'h1 : q2 - 2'h1;
	end
endmodule

// ==== verification/testbench.sv ====
// Purpose: Self-checking bench for the motor supervisor.
// Assumes: Short blink, pause and flicker parameters.
// Notes:   Expectations come from the model functions here.
`timescale 1ns/1ps
module testbench;
	import motor_supervisor_pkg::*;
	localparam int BL = 8;
	localparam int PS = 40;
	localparam int FL = 3;
	logic clk = 1'h0, rst = 1'h1, low = 1'h0, stp = 1'h0, chn = 1'h0, up = 1'h0;
	logic pul = 1'h0, byt = 1'h0, awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rrd = 1'h0;
	logic [9:0] sw = 10'h000;
	logic [1:0] act = 2'h0;
	logic [5:0] flt = 6'h00;
	logic [15:0] mv = 16'h0000;
	logic [11:0] awa = 12'h000, ara = 12'h000;
	logic [31:0] wd = 32'h0000_0000, lf = 32'h0001_67D7, rd;
	logic [1:0] rr, m, bresp, rresp, wb;
	logic p, u, awr, wr, bv, arr, rv, l1, l2, le, est, flp, men, fen, a1, b1, a2, b2, s3;
	logic [31:0] rdata;
	mode_t md;
	int failures = 0, cmp_count = 0, n, e1;
	always #2.5 clk = ~clk;
	field_model fm (.core_clk_in(clk), .step_in(stp), .chan_in(chn), .up_in(up), .low_in(low),
		.a1_out(a1), .b1_out(b1), .a2_out(a2), .b2_out(b2), .third_out(s3));
	motor_supervisor #(.BLINK_CYCLES(BL), .PAUSE_CYCLES(PS), .FLICKER_CYCLES(FL)) uut (
		.core_clk_in(clk), .rst_in(rst), .switches_in(sw), .flip_or_estop_input_in(s3),
		.enc1_a_in(a1), .enc1_b_in(b1), .enc2_a_in(a2), .enc2_b_in(b2),
		.cmd_pulse_seen_in(pul), .serial_byte_seen_in(byt), .motor1_active_in(act[0]),
		.motor2_active_in(act[1]), .overcurrent1_in(flt[0]), .overcurrent2_in(flt[1]),
		.overtemp_in(flt[2]), .main_high_in(flt[3]), .logic_low_in(flt[4]),
		.logic_high_in(flt[5]), .main_supply_mv_in(mv), .s_axi_awaddr(awa),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
		.s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rrd),
		.status_led1_out(l1), .status_led2_out(l2), .error_led_out(le), .mode_out(md),
		.estop_out(est), .flip_out(flp), .motor_enable_out(men), .feedback_enable_out(fen));
	function automatic logic [31:0] nx(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function automatic logic [1:0] em(input logic [2:0] s);
		return s[0] ? 2'h0 : s == 3'h0 ? 2'h1 : s[1] ? 2'h2 : 2'h3;
	endfunction
	function automatic int th(input int c);
		return c == 1 ? int'(LEAD_AUTO_MV) : 6000 + 3000 * (c - 2);
	endfunction
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic cy(input int k);
		repeat (k) @(posedge clk);
	endtask
	// Counts changes of the error indicator, or only its rises when any is low.
	task automatic cnt(input int len, input logic any);
		n = 0;
		p = 1'h0;
		repeat (len) begin
			@(posedge clk);
			n += int'(le != p && (any || le));
			p = le;
		end
	endtask
	task automatic axw(input logic [11:0] a, input logic [31:0] d);
		awa <= a;
		wd <= d;
		awv <= 1'h1;
		wv <= 1'h1;
		br <= 1'h1;
		do begin
			@(posedge clk);
			if (awr) awv <= 1'h0;
			if (wr) wv <= 1'h0;
		end while (!bv);
		wb = bresp;
		br <= 1'h0;
		@(posedge clk);
	endtask
	task automatic axr(input logic [11:0] a);
		ara <= a;
		arv <= 1'h1;
		rrd <= 1'h1;
		do begin
			@(posedge clk);
			if (arr) arv <= 1'h0;
		end while (!rv);
		rd = rdata;
		rr = rresp;
		rrd <= 1'h0;
		@(posedge clk);
	endtask
	initial begin
		cy(16);
		rst <= 1'h0;
		n = 0;
		repeat (46) begin
			@(posedge clk);
			chk(32'({l1, l2}), 32'({le, le}));
			n += int'(le);
		end
		chk(32'(n), 32'(TEST_FLASHES * BL));
		$display("self-test done");
		for (int i = 0; i < 32; i++) begin
			sw <= 10'({i[3], 3'h0, i[2:0]});
			low <= i[4];
			cy(4);
			m = em(3'(i));
			chk(32'(md), 32'(m));
			chk(32'(est), 32'(m > 1 && i[4]));
			chk(32'(flp), 32'(i[4] && (m == 0 && !i[3] || m == 1 && i[3])));
			chk(32'(fen), 32'(m > 1));
		end
		$display("mode test done");
		low <= 1'h0;
		for (int c = 0; c < 8; c++) begin
			for (int k = 0; k < 2; k++) begin
				sw <= 10'(c << 7);
				mv <= 16'(th(c) - 1 + k);
				cy(4);
				u = c != 0 && k == 0;
				chk(32'(men), 32'(!u));
				axr(REG_STATUS);
				chk(32'(rd[7:2]), 32'({u, 2'h0, 3'(c)}));
			end
		end
		$display("cutoff test done");
		for (int j = 0; j < 4; j++) begin
			sw <= 10'(j == 0 ? 0 : 1 << (j - 1));
			act <= 2'(j);
			cy(4);
			chk(32'({l1, l2}), 32'({1'h1, j != 0}));
			pul <= j < 2;
			byt <= j > 1;
			@(posedge clk);
			pul <= 1'h0;
			byt <= 1'h0;
			cy(4);
			chk(32'(l1), 32'(j == 0));
			cy(10);
			chk(32'(l1), 32'h0000_0001);
		end
		$display("status test done");
		act <= 2'h0;
		for (int b = 4; b > 0; b--) begin
			flt <= {b != 2, b == 3 || b == 1, 1'h0, b == 1, 2'h0};
			sw <= b < 3 ? 10'h380 : 10'h000;
			mv <= 16'h0000;
			cnt(b * 2 * BL + PS - 4, 1'h0);
			chk(32'(n), 32'(b));
			flt <= 6'h00;
			sw <= 10'h000;
			cy(6);
		end
		flt <= 6'h08;
		cnt(10 * FL, 1'h1);
		chk(32'(n > 8 && n < 12), 32'h0000_0001);
		flt <= 6'h00;
		cy(4);
		cnt(12, 1'h1);
		chk(32'(n), 32'h0000_0000);
		for (int c = 1; c < 3; c++) begin
			flt <= 6'(c) | 6'h04;
			cy(3);
			cnt(20, 1'h1);
			chk(32'({n == 1, le, l1, l2}), 32'({2'h3, c == 1, c == 2}));
		end
		$display("error test done");
		flt <= 6'h00;
		for (int c = 0; c < 2; c++) begin
			axw(REG_CTRL, 32'h0000_0003);
			chk(32'(wb), 32'(RESP_OKAY));
			axr(REG_CTRL);
			chk(rd, 32'h0000_0003);
			axw(REG_CTRL, 32'h0000_0000);
			lf = nx(lf);
			e1 = 0;
			for (int s = 0; s < 24; s++) begin
				stp <= lf[s];
				chn <= c[0];
				up <= lf[s + 8];
				@(posedge clk);
				stp <= 1'h0;
				cy(3);
				e1 += lf[s] ? (lf[s + 8] ? 1 : -1) : 0;
			end
			cy(4);
			axr(c == 1 ? REG_ENC2 : REG_ENC1);
			chk(rd, 32'(e1));
		end
		axw(12'h010, 32'h0000_0001);
		chk(32'(wb), 32'(RESP_SLVERR));
		axr(12'h010);
		chk(32'({rr, rd[29:0]}), 32'({RESP_SLVERR, 30'h0000_0000}));
		$display("encoder test done");
		report_and_stop();
	end
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		report_and_stop();
	end
endmodule
